// ---- verilog/serial_flash_map.svh ----
// Offsets, field positions, opcodes and timing counts of the page-program block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef SERIAL_FLASH_MAP_SVH
`define SERIAL_FLASH_MAP_SVH

// Register port offsets (byte addresses)
`define REG_CFG 8'h00
`define REG_STAT 8'h04
`define REG_MADDR 8'h08
`define REG_MDATA 8'h0C

// Configuration field positions and reset value
`define CFG_QUAD_BIT 0
`define CFG_LONG_BIT 1
`define CFG_RESET 2'h0

// Status field positions
`define SR1_WIP_BIT 0
`define SR1_LOCK_BIT 1
`define SR1_FAIL_BIT 6
`define SR2_PAUSE_BIT 0

// Opcodes
`define OP_UNLOCK 8'h06
`define OP_READ_STATUS_ONE_CMD 8'h05
`define OP_READ_STATUS_TWO_CMD 8'h07
`define OP_PAGE 8'h02
`define OP_PAGE_LONG 8'h12
`define OP_QUAD_A 8'h32
`define OP_QUAD_B 8'h38
`define OP_QUAD_LONG 8'h34
`define OP_PAUSE 8'h85
`define OP_CONT 8'h8A

// Address lengths in bits
`define ADDR_SHORT 6'h18
`define ADDR_LONG 6'h20

// Timing
`define CLK_PERIOD_NS 8
`define PROG_BYTE_NS 80
`define PROG_BYTE_CYC ((`PROG_BYTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_LATENCY_NS 1000
`define SUSPEND_LATENCY_CYC (`SUSPEND_LATENCY_NS / `CLK_PERIOD_NS)

`endif

// ---- verilog/serial_flash_pkg.sv ----
// State types of the page-program block.
// Assumes nothing of its surroundings.
`default_nettype none
package serial_flash_pkg;
  typedef enum logic [5:0] {
    C_SKIP = 6'h01,
    C_OPC = 6'h02,
    C_ADDR = 6'h04,
    C_DATA = 6'h08,
    C_STAT = 6'h10,
    C_HOLD = 6'h20
  } cmd_state_t;
  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_RUN = 4'h2,
    E_PAUSING = 4'h4,
    E_PAUSED = 4'h8
  } eng_state_t;
endpackage
`default_nettype wire

// ---- verilog/serial_flash_page_program.sv ----
// Page-program command logic of a serial NOR flash, with a small internal array.
// Assumes SCK, CS_N and IO_IN come from a host in mode 0, far slower than CLK.
// Summary of operation
// - One program command covers at most one page of 256 or 512 bytes.
// - Pages align on page-size boundaries; any subset of a page may change.
// - Program accepted only after unlock command has set the unlock latch.
// - Opcode 02h takes 3 or 4 address bytes by select; 12h takes 4.
// - Data past page end wraps to page start using low address bits.
// - Short loads program bytes in sequence, leaving other page bytes untouched.
// - Programming only clears bits from 1 to 0.
// - Status one bit 0 shows busy; bit 6 shows program failure.
// - Quad opcodes 32h, 38h use select; 34h takes 4 bytes; data four bits per clock.
// - Quad program needs quad enable set and unlock latch set.
// - Quad program treats whole page programmed; unloaded bytes stay ones.
// - Pause 85h acts only while programming runs.
// - After pause, status one and status two reads are accepted.
// - Pause done: busy drops, status two bit 0 shows paused.
// - Continue 8Ah resumes a paused program, else ignored.
// - Accepted continue sets busy again and carries on programming.
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_map.svh"

module serial_flash_page_program #(
  parameter bit ORDER_PAGE_512 = 1'b1,
  parameter int MEM_AW = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  output logic SO_OUT,
  output logic SO_OE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);

  function automatic logic [8:0] page_mask(input logic p512);
    return p512 ? 9'h1FF : 9'h0FF;
  endfunction

  function automatic logic [5:0] addr_bits(input logic [7:0] opc, input logic long_sel);
    return (opc == `OP_PAGE_LONG || opc == `OP_QUAD_LONG || long_sel) ? `ADDR_LONG : `ADDR_SHORT;
  endfunction

  localparam logic [8:0] PMASK = page_mask(ORDER_PAGE_512);
  localparam logic [7:0] PROG_LAST = 8'(`PROG_BYTE_CYC - 1);
  localparam logic [7:0] SUSP_LAST = 8'(`SUSPEND_LATENCY_CYC - 1);
  localparam int SUSP_MAX = `SUSPEND_LATENCY_CYC + 1;

  logic rst_s1, rst_n;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Link inputs pass two flops; the third sck/cs stage only feeds edge detection
  logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3;
  logic [3:0] io_s1, io_s2;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      {sck_s1, sck_s2, sck_s3} <= {SCK, sck_s1, sck_s2};
      {cs_s1, cs_s2, cs_s3} <= {CS_N, cs_s1, cs_s2};
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
    end
  end
  wire sck_rise = sck_s2 & ~sck_s3;
  wire sck_fall = ~sck_s2 & sck_s3;
  wire cs_fall = ~cs_s2 & cs_s3;
  wire cs_rise = cs_s2 & ~cs_s3;
  wire sel = ~cs_s2;

  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic [7:0] pbuf [0:511];

  serial_flash_pkg::cmd_state_t cst_r, cst_nxt;
  serial_flash_pkg::eng_state_t est_r, est_nxt;
  logic [7:0] opc_r, opc_nxt, sh_r, sh_nxt, so_sh_r, so_sh_nxt;
  logic [5:0] bits_r, bits_nxt, alen_r, alen_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [9:0] nb_r, nb_nxt;
  logic quad_r, quad_nxt, lock_r, lock_nxt, so_r, so_nxt, so_oe_r, so_oe_nxt;
  logic [511:0] loaded_r, loaded_nxt;
  logic buf_we, start_go, pause_go, cont_go;
  logic [8:0] buf_idx;
  logic [7:0] buf_dat, byte_in;
  logic [1:0] cfg_r, cfg_nxt;
  logic [MEM_AW-1:0] maddr_r, maddr_nxt, base_r, base_nxt, mem_wa;
  logic [31:0] rdata_r, rdata_nxt;
  logic [8:0] eidx_r, eidx_nxt;
  logic [7:0] etmr_r, etmr_nxt, mem_wd, src;
  logic equad_r, equad_nxt, fail_r, fail_nxt, mem_we;
  logic [7:0] sr1, sr2;
  wire idle = (est_r == serial_flash_pkg::E_IDLE);

  always_comb begin
    sr1 = 8'h00;
    sr1[`SR1_WIP_BIT] = (est_r == serial_flash_pkg::E_RUN) || (est_r == serial_flash_pkg::E_PAUSING);
    sr1[`SR1_LOCK_BIT] = lock_r;
    sr1[`SR1_FAIL_BIT] = fail_r;
    sr2 = 8'h00;
    sr2[`SR2_PAUSE_BIT] = (est_r == serial_flash_pkg::E_PAUSED);
  end

  // Command decoder, driven by sampled link edges
  always_comb begin
    cst_nxt = cst_r;
    opc_nxt = opc_r;
    sh_nxt = sh_r;
    bits_nxt = bits_r;
    addr_nxt = addr_r;
    nb_nxt = nb_r;
    quad_nxt = quad_r;
    alen_nxt = alen_r;
    lock_nxt = lock_r;
    so_sh_nxt = so_sh_r;
    so_nxt = so_r;
    so_oe_nxt = so_oe_r;
    loaded_nxt = loaded_r;
    buf_we = 1'b0;
    buf_idx = 9'h000;
    buf_dat = 8'h00;
    start_go = 1'b0;
    pause_go = 1'b0;
    cont_go = 1'b0;
    byte_in = {sh_r[6:0], io_s2[0]};
    if (cs_fall) begin
      cst_nxt = serial_flash_pkg::C_OPC;
      bits_nxt = 6'h00;
      nb_nxt = 10'h000;
    end else if (cs_rise) begin
      so_oe_nxt = 1'b0;
      cst_nxt = serial_flash_pkg::C_SKIP;
      if (cst_r == serial_flash_pkg::C_HOLD) begin
        if (opc_r == `OP_UNLOCK) lock_nxt = 1'b1;
        if (opc_r == `OP_PAUSE) pause_go = 1'b1;
        if (opc_r == `OP_CONT) cont_go = 1'b1;
      end
      // A frame with no data byte starts nothing
      if (cst_r == serial_flash_pkg::C_DATA && nb_r != 10'h000) begin
        start_go = 1'b1;
        lock_nxt = 1'b0;
      end
    end else if (sel && sck_rise) begin
      case (cst_r)
        serial_flash_pkg::C_OPC: begin
          sh_nxt = byte_in;
          bits_nxt = bits_r + 6'h01;
          if (bits_r == 6'h07) begin
            opc_nxt = byte_in;
            bits_nxt = 6'h00;
            cst_nxt = serial_flash_pkg::C_SKIP;
            case (byte_in)
              `OP_UNLOCK, `OP_PAUSE, `OP_CONT: cst_nxt = serial_flash_pkg::C_HOLD;
              `OP_READ_STATUS_ONE_CMD, `OP_READ_STATUS_TWO_CMD: begin
                cst_nxt = serial_flash_pkg::C_STAT;
                so_sh_nxt = (byte_in == `OP_READ_STATUS_ONE_CMD) ? sr1 : sr2;
                so_oe_nxt = 1'b1;
              end
              `OP_PAGE, `OP_PAGE_LONG: begin
                if (lock_r && idle) begin
                  cst_nxt = serial_flash_pkg::C_ADDR;
                  quad_nxt = 1'b0;
                  alen_nxt = addr_bits(byte_in, cfg_r[`CFG_LONG_BIT]);
                  loaded_nxt = '0;
                end
              end
              `OP_QUAD_A, `OP_QUAD_B, `OP_QUAD_LONG: begin
                if (lock_r && idle && cfg_r[`CFG_QUAD_BIT]) begin
                  cst_nxt = serial_flash_pkg::C_ADDR;
                  quad_nxt = 1'b1;
                  alen_nxt = addr_bits(byte_in, cfg_r[`CFG_LONG_BIT]);
                  loaded_nxt = '0;
                end
              end
              default: ;
            endcase
          end
        end
        serial_flash_pkg::C_ADDR: begin
          addr_nxt = {addr_r[30:0], io_s2[0]};
          bits_nxt = bits_r + 6'h01;
          if (bits_r == alen_r - 6'h01) begin
            bits_nxt = 6'h00;
            cst_nxt = serial_flash_pkg::C_DATA;
          end
        end
        serial_flash_pkg::C_DATA: begin
          sh_nxt = quad_r ? {sh_r[3:0], io_s2} : byte_in;
          bits_nxt = bits_r + 6'h01;
          if (bits_r == (quad_r ? 6'h01 : 6'h07)) begin
            bits_nxt = 6'h00;
            buf_we = 1'b1;
            buf_dat = sh_nxt;
            buf_idx = (addr_r[8:0] + nb_r[8:0]) & PMASK;
            loaded_nxt[buf_idx] = 1'b1;
            if (nb_r != 10'h3FF) nb_nxt = nb_r + 10'h001;
          end
        end
        serial_flash_pkg::C_HOLD: cst_nxt = serial_flash_pkg::C_SKIP;
        default: ;
      endcase
    end else if (sel && sck_fall && cst_r == serial_flash_pkg::C_STAT) begin
      so_nxt = so_sh_r[7];
      so_sh_nxt = {so_sh_r[6:0], so_sh_r[7]};
    end
  end

  // Program engine; one byte slot per PROG_BYTE_CYC cycles
  always_comb begin
    est_nxt = est_r;
    eidx_nxt = eidx_r;
    etmr_nxt = etmr_r;
    base_nxt = base_r;
    equad_nxt = equad_r;
    fail_nxt = fail_r;
    mem_we = 1'b0;
    mem_wa = base_r | MEM_AW'(eidx_r);
    src = loaded_r[eidx_r] ? pbuf[eidx_r] : 8'hFF;
    mem_wd = mem[mem_wa] & src;
    case (est_r)
      serial_flash_pkg::E_IDLE: begin
        if (start_go) begin
          est_nxt = serial_flash_pkg::E_RUN;
          base_nxt = addr_r[MEM_AW-1:0] & ~MEM_AW'(PMASK);
          eidx_nxt = 9'h000;
          etmr_nxt = 8'h00;
          equad_nxt = quad_r;
          fail_nxt = 1'b0;
        end
      end
      serial_flash_pkg::E_RUN: begin
        if (pause_go) begin
          est_nxt = serial_flash_pkg::E_PAUSING;
          etmr_nxt = 8'h00;
        end else if (etmr_r == PROG_LAST) begin
          etmr_nxt = 8'h00;
          // Untouched bytes of a short single-lane load are skipped
          mem_we = loaded_r[eidx_r] | equad_r;
          // Quad data over unerased bytes cannot complete correctly
          if (equad_r && loaded_r[eidx_r] && mem[mem_wa] != 8'hFF) fail_nxt = 1'b1;
          if (eidx_r == PMASK) est_nxt = serial_flash_pkg::E_IDLE;
          else eidx_nxt = eidx_r + 9'h001;
        end else begin
          etmr_nxt = etmr_r + 8'h01;
        end
      end
      serial_flash_pkg::E_PAUSING: begin
        if (etmr_r == SUSP_LAST) est_nxt = serial_flash_pkg::E_PAUSED;
        else etmr_nxt = etmr_r + 8'h01;
      end
      serial_flash_pkg::E_PAUSED: begin
        if (cont_go) begin
          est_nxt = serial_flash_pkg::E_RUN;
          etmr_nxt = 8'h00;
        end
      end
      default: est_nxt = serial_flash_pkg::E_IDLE;
    endcase
  end

  // Register port
  always_comb begin
    cfg_nxt = cfg_r;
    maddr_nxt = maddr_r;
    rdata_nxt = 32'h0000_0000;
    if (WR && ADDR == `REG_CFG) cfg_nxt = WDATA[1:0];
    if (WR && ADDR == `REG_MADDR) maddr_nxt = WDATA[MEM_AW-1:0];
    if (RD) begin
      case (ADDR)
        `REG_CFG: rdata_nxt = {30'h0, cfg_r};
        `REG_STAT: rdata_nxt = {16'h0, sr2, sr1};
        `REG_MADDR: rdata_nxt = 32'(maddr_r);
        `REG_MDATA: rdata_nxt = {24'h0, mem[maddr_r]};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cst_r <= serial_flash_pkg::C_SKIP;
      est_r <= serial_flash_pkg::E_IDLE;
      {opc_r, sh_r, so_sh_r} <= 24'h0;
      {bits_r, alen_r} <= 12'h0;
      addr_r <= 32'h0;
      nb_r <= 10'h0;
      {quad_r, lock_r, so_r, so_oe_r, equad_r, fail_r} <= 6'h0;
      loaded_r <= '0;
      cfg_r <= `CFG_RESET;
      maddr_r <= '0;
      base_r <= '0;
      rdata_r <= 32'h0;
      eidx_r <= 9'h0;
      etmr_r <= 8'h0;
    end else begin
      cst_r <= cst_nxt;
      est_r <= est_nxt;
      {opc_r, sh_r, so_sh_r} <= {opc_nxt, sh_nxt, so_sh_nxt};
      {bits_r, alen_r} <= {bits_nxt, alen_nxt};
      addr_r <= addr_nxt;
      nb_r <= nb_nxt;
      {quad_r, lock_r, so_r, so_oe_r, equad_r, fail_r} <= {quad_nxt, lock_nxt, so_nxt, so_oe_nxt, equad_nxt, fail_nxt};
      loaded_r <= loaded_nxt;
      cfg_r <= cfg_nxt;
      maddr_r <= maddr_nxt;
      base_r <= base_nxt;
      rdata_r <= rdata_nxt;
      eidx_r <= eidx_nxt;
      etmr_r <= etmr_nxt;
    end
  end

  // Arrays carry no reset; engine write wins over a software byte write
  always_ff @(posedge CLK) begin
    if (buf_we) pbuf[buf_idx] <= buf_dat;
    if (mem_we) mem[mem_wa] <= mem_wd;
    else if (WR && ADDR == `REG_MDATA) mem[maddr_r] <= WDATA[7:0];
  end

  assign SO_OUT = so_r;
  assign SO_OE = so_oe_r;
  assign RDATA = rdata_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  start_needs_lock_a: assert property (start_go |-> lock_r && idle) else $error("program started while locked");
  lock_consumed_a: assert property (start_go |=> !lock_r && sr1[`SR1_WIP_BIT]) else $error("start did not lock and busy");
  quad_gate_a: assert property (quad_nxt && cst_nxt == serial_flash_pkg::C_ADDR
    && cst_r == serial_flash_pkg::C_OPC |-> cfg_r[`CFG_QUAD_BIT] && lock_r)
    else $error("quad accepted without enable");
  wrap_index_a: assert property (buf_we |-> (buf_idx & ~PMASK) == 9'h000) else $error("buffer index left page");
  clear_only_a: assert property (mem_we |-> (mem_wd & ~mem[mem_wa]) == 8'h00) else $error("bit set by program");
  pause_latency_a: assert property (est_r == serial_flash_pkg::E_RUN && pause_go
    |-> ##[1:SUSP_MAX] (sr2[`SR2_PAUSE_BIT] && !sr1[`SR1_WIP_BIT])) else $error("pause too slow");
  pause_idle_a: assert property (idle && pause_go |=> idle) else $error("pause acted while idle");
  cont_idle_a: assert property (idle && cont_go |=> idle && !sr1[`SR1_WIP_BIT]) else $error("continue acted while idle");
  cont_resume_a: assert property (est_r == serial_flash_pkg::E_PAUSED && cont_go
    |=> sr1[`SR1_WIP_BIT] && $stable(eidx_r)) else $error("continue did not resume");
  short_skip_a: assert property (est_r == serial_flash_pkg::E_RUN && !equad_r && !loaded_r[eidx_r]
    |-> !mem_we) else $error("unloaded byte written");

  single_prog_c: cover property (start_go && !quad_r);
  quad_prog_c: cover property (start_go && quad_r);
  pause_resume_c: cover property (est_r == serial_flash_pkg::E_PAUSED && cont_go);

endmodule // serial_flash_page_program
`default_nettype wire

// ---- verif/spi_host_model.sv ----
// Host-side serial model: frames in SPI mode 0, MSB first, single or quad lane.
// Assumes CLK is the bench clock; SCK half period is five CLK cycles.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic CLK,
  // Serial link
  output logic SCK,
  output logic CS_N,
  output logic [3:0] IO_IN,
  input wire logic SO_OUT,
  input wire logic SO_OE
);
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    IO_IN = 4'hA;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // 12.5 MHz SCK, far below the quad limit
  task automatic pulse(input logic [3:0] v);
    IO_IN <= v;
    tick(5);
    SCK <= 1'b1;
    tick(5);
    SCK <= 1'b0;
  endtask
  task automatic start();
    CS_N <= 1'b0;
    tick(5);
  endtask
  // Unused lanes toggle so a stale level never reads as data
  task automatic send_byte(input logic [7:0] b, input bit quad);
    int i;
    if (quad) begin
      pulse(b[7:4]);
      pulse(b[3:0]);
    end else begin
      for (i = 7; i >= 0; i--)
        pulse({~IO_IN[3:1], b[i]});
    end
  endtask
  task automatic get_byte(output logic [7:0] b, output logic oe);
    int i;
    oe = 1'b1;
    for (i = 7; i >= 0; i--) begin
      IO_IN <= ~IO_IN;
      tick(5);
      b[i] = SO_OUT;
      oe = oe & SO_OE;
      SCK <= 1'b1;
      tick(5);
      SCK <= 1'b0;
    end
  endtask
  // Released lines show the inverse of their last level
  task automatic finish();
    tick(5);
    CS_N <= 1'b1;
    IO_IN <= ~IO_IN;
    tick(10);
  endtask
endmodule // spi_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench of the page-program block with a serial host model.
// Assumes the design and the host model are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_map.svh"
module tb_top;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic SCK, CS_N, SO_OUT, SO_OE;
  logic [3:0] IO_IN;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'hF006EB34;
  logic [31:0] last;
  logic [7:0] dbuf [0:15];
  bit cfg_long = 1'b0;
  localparam logic [7:0] TO [0:5] = '{`OP_PAGE, `OP_PAGE_LONG, `OP_PAGE, `OP_QUAD_A, `OP_QUAD_B, `OP_QUAD_LONG};
  localparam bit TL [0:5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] TP [0:5] = '{8'hFF, 8'hFF, 8'h3C, 8'hFF, 8'hFF, 8'h0F};
  localparam logic [31:0] WA [0:3] = '{32'h3FE, 32'h3FF, 32'h200, 32'h201};

  always #4 CLK = ~CLK;

  serial_flash_page_program serial_flash_page_program_inst (
    .CLK(CLK), .RESETN(RESETN), .SCK(SCK), .CS_N(CS_N), .IO_IN(IO_IN), .SO_OUT(SO_OUT),
    .SO_OE(SO_OE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA)
  );
  spi_host_model host_inst (
    .CLK(CLK), .SCK(SCK), .CS_N(CS_N), .IO_IN(IO_IN), .SO_OUT(SO_OUT), .SO_OE(SO_OE)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Note the expectation; the monitor compares when the data stand
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    last = RDATA;
  endtask
  always @(posedge CLK) begin
    logic [31:0] e;
    logic [31:0] m;
    rd_d <= RD;
    if (rd_d === 1'b1 && q_exp.size() > 0) begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      chk("rdata", e, RDATA & m);
    end
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic mem_wr(input logic [31:0] a, input logic [7:0] d);
    wr(`REG_MADDR, a & 32'hFFF);
    wr(`REG_MDATA, {24'h0, d});
  endtask
  task automatic mem_chk(input logic [31:0] a, input logic [7:0] e);
    wr(`REG_MADDR, a & 32'hFFF);
    rd(`REG_MDATA, {24'h0, e}, 32'hFF);
  endtask
  task automatic cmd(input logic [7:0] op);
    host_inst.start();
    host_inst.send_byte(op, 1'b0);
    host_inst.finish();
  endtask
  // At least one and at most 16 data bytes, the size of dbuf
  task automatic prog(input logic [7:0] op, input int n, input logic [31:0] a);
    int i;
    int ab;
    bit q;
    q = (op == `OP_QUAD_A || op == `OP_QUAD_B || op == `OP_QUAD_LONG);
    ab = (op == `OP_PAGE_LONG || op == `OP_QUAD_LONG || cfg_long) ? 4 : 3;
    host_inst.start();
    host_inst.send_byte(op, 1'b0);
    for (i = ab - 1; i >= 0; i--)
      host_inst.send_byte(a[8*i +: 8], 1'b0);
    for (i = 0; i < n; i++)
      host_inst.send_byte(dbuf[i], q);
    host_inst.finish();
  endtask
  task automatic status(input logic [7:0] op, input logic [7:0] e);
    logic [7:0] b;
    logic oe;
    host_inst.start();
    host_inst.send_byte(op, 1'b0);
    host_inst.get_byte(b, oe);
    host_inst.finish();
    chk("serial status", {24'h0, e}, {24'h0, b});
    chk("status drive", 32'h1, {31'h0, oe});
    chk("status release", 32'h0, {31'h0, SO_OE});
  endtask
  // Polls are not compared; the busy bit or the 4000-poll limit ends the wait
  task automatic wait_idle();
    int k;
    for (k = 0; k < 4000; k++) begin
      rd(`REG_STAT, 32'h0, 32'h0);
      if (last[`SR1_WIP_BIT] === 1'b0)
        break;
    end
    if (k == 4000)
      chk("idle wait", 32'h0, 32'h1);
  endtask

  initial begin : main
    int i;
    int k;
    logic [31:0] a;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(`REG_CFG, 32'h0, 32'hFFFFFFFF);
    rd(`REG_STAT, 32'h0, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    // Program while locked leaves the array alone
    mem_wr(32'h100, 8'hAA);
    dbuf[0] = 8'h00;
    prog(`OP_PAGE, 1, 32'h100);
    host_inst.tick(20);
    rd(`REG_STAT, 32'h0, 32'hFFFFFFFF);
    mem_chk(32'h100, 8'hAA);
    // Wrap across the page end, with a pause and resume in the middle
    for (i = 0; i < 4; i++)
      mem_wr(WA[i], 8'hF0);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      dbuf[i] = seed[7:0];
    end
    cmd(`OP_UNLOCK);
    rd(`REG_STAT, 32'h2, 32'hFFFFFFFF);
    prog(`OP_PAGE, 3, 32'h3FE);
    host_inst.tick(100);
    cmd(`OP_PAUSE);
    host_inst.tick(130);
    rd(`REG_STAT, 32'h100, 32'hFFFFFFFF);
    status(`OP_READ_STATUS_ONE_CMD, 8'h00);
    status(`OP_READ_STATUS_TWO_CMD, 8'h01);
    // No further pause follows the resume, so the run can complete
    cmd(`OP_CONT);
    rd(`REG_STAT, 32'h1, 32'hFFFFFFFF);
    wait_idle();
    rd(`REG_STAT, 32'h0, 32'hFFFFFFFF);
    for (i = 0; i < 3; i++)
      mem_chk(WA[i], dbuf[i] & 8'hF0);
    mem_chk(WA[3], 8'hF0);
    cmd(`OP_CONT);
    rd(`REG_STAT, 32'h0, 32'hFFFFFFFF);
    cmd(`OP_PAUSE);
    rd(`REG_STAT, 32'h0, 32'hFFFFFFFF);
    // One aligned 16-byte block over erased bytes
    for (i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      dbuf[i] = seed[7:0];
      mem_wr(i, 8'hFF);
    end
    cmd(`OP_UNLOCK);
    prog(`OP_PAGE, 16, 32'h0);
    wait_idle();
    for (i = 0; i < 16; i++)
      mem_chk(i, dbuf[i]);
    // Quad refused while the lane enable is off
    mem_wr(32'h300, 8'hFF);
    cmd(`OP_UNLOCK);
    prog(`OP_QUAD_A, 1, 32'h300);
    host_inst.tick(20);
    rd(`REG_STAT, 32'h2, 32'hFFFFFFFF);
    mem_chk(32'h300, 8'hFF);
    // Every program opcode once and 02h under both address selects, one fresh page per pass
    for (i = 0; i < 6; i++) begin
      a = 32'hA5000405 + 32'h200 * i;
      cfg_long = TL[i];
      wr(`REG_CFG, {30'h0, TL[i], 1'b1});
      rd(`REG_CFG, {30'h0, TL[i], 1'b1}, 32'hFFFFFFFF);
      // Quad rewrites the whole page; every byte is erased first, though only loaded bytes need it
      if (i > 2)
        for (k = 0; k < 512; k++)
          mem_wr((a & 32'hFFFFFE00) + k, 8'hFF);
      mem_wr(a, TP[i]);
      mem_wr(a + 1, 8'hFF);
      seed = lfsr(seed);
      dbuf[0] = seed[7:0];
      cmd(`OP_UNLOCK);
      prog(TO[i], 1, a);
      wait_idle();
      rd(`REG_STAT, (i == 5) ? 32'h40 : 32'h0, 32'hFFFF);
      mem_chk(a, TP[i] & dbuf[0]);
      mem_chk(a + 1, 8'hFF);
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire
